/* File: tpa_pkg.sv */
// package for the table pointer access block: register map, fields, op encodings
package tpa_pkg;
  // register indices on the plain register port
  localparam logic [2:0] TPA_ADDR_LATCH  = 3'h0;
  localparam logic [2:0] TPA_ADDR_PTR_LO = 3'h1;
  localparam logic [2:0] TPA_ADDR_PTR_HI = 3'h2;
  localparam logic [2:0] TPA_ADDR_PTR_UP = 3'h3;
  localparam logic [2:0] TPA_ADDR_CTRL   = 3'h4;
  localparam logic [2:0] TPA_ADDR_STAT   = 3'h5;
  // widths and field positions
  localparam int TPA_PTR_W     = 22;
  localparam int TPA_ADDR_W    = 21;
  localparam int TPA_CFG_BIT   = 21;
  localparam int TPA_HOLD_LSB  = 5;
  localparam int TPA_BLK_LSB   = 6;
  localparam int TPA_UP_W      = 6;
  localparam int TPA_CTRL_WR   = 0;
  localparam int TPA_CTRL_ER   = 1;
  // reset values
  localparam logic [7:0]  TPA_LATCH_RST = 8'h00;
  localparam logic [21:0] TPA_PTR_RST   = 22'h000000;
  localparam logic [7:0]  TPA_HOLD_RST  = 8'hFF;
  localparam logic [7:0]  TPA_ZERO8     = 8'h00;
  // pointer update forms of the table read and write operations
  typedef enum logic [1:0] {
    TPA_UPD_NONE = 2'h0,
    TPA_UPD_POST_INC = 2'h1,
    TPA_UPD_POST_DEC = 2'h2,
    TPA_UPD_PRE_INC = 2'h3
  } tpa_upd_t;
  // table operation request from the core
  typedef struct packed {
    logic     rd;
    logic     wr;
    tpa_upd_t upd;
  } tpa_op_t;
  // request towards the flash array
  typedef struct packed {
    logic        rd;
    logic        prog;
    logic        erase;
    logic        cfg;
    logic [20:0] addr;
  } tpa_mem_req_t;
endpackage : tpa_pkg

/* File: tpa_table_access.sv */
// table pointer, table latch and flash holding registers of the processor core
module tpa_table_access #(
  parameter int HOLD_N = 32
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [2:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [7:0]                 reg_rdata_o,
  input  wire tpa_pkg::tpa_op_t      op_i,
  output tpa_pkg::tpa_mem_req_t      mem_req_o,
  input  wire logic [7:0]            mem_rdata_i,
  input  wire logic                  mem_done_i,
  output logic [7:0]                 hold_data_o,
  input  wire logic [4:0]            hold_idx_i,
  output logic                       busy_o
);
  import tpa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {TPA_IDLE, TPA_READ, TPA_TIMED} tpa_state_t;

  tpa_state_t         state_q;
  logic [7:0]         latch_q;
  logic [21:0]        ptr_q;
  logic [21:0]        ptr_inc;
  logic [21:0]        ptr_dec;
  logic [21:0]        ptr_acc;
  logic               rd_go;
  logic               timed_go;
  logic               ctrl_wr;
  logic [7:0]         hold_q [HOLD_N];
  tpa_mem_req_t       mem_req_q;
  logic [7:0]         rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // pointer arithmetic

  // only the low 21 bits wrap; the space select bit is carried over as is
  assign ptr_inc = {ptr_q[TPA_CFG_BIT],
                    ptr_q[TPA_ADDR_W-1:0] + 21'h000001};
  assign ptr_dec = {ptr_q[TPA_CFG_BIT],
                    ptr_q[TPA_ADDR_W-1:0] - 21'h000001};
  // pre-increment accesses the updated address, others the current one
  assign ptr_acc = (op_i.upd == TPA_UPD_PRE_INC) ? ptr_inc : ptr_q;

  // operations are refused while a read or timed operation is in flight
  assign rd_go    = (state_q == TPA_IDLE) && op_i.rd;
  assign ctrl_wr  = reg_wr_i && (reg_addr_i == TPA_ADDR_CTRL);
  assign timed_go = (state_q == TPA_IDLE) && ctrl_wr && !op_i.rd && !op_i.wr;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= TPA_IDLE;
    end else begin
      unique case (state_q)
        TPA_IDLE: begin
          if (rd_go) begin
            state_q <= TPA_READ;
          end else if (timed_go && (reg_wdata_i[TPA_CTRL_WR] || reg_wdata_i[TPA_CTRL_ER])) begin
            state_q <= TPA_TIMED;
          end
        end
        TPA_READ: begin
          if (mem_done_i) begin
            state_q <= TPA_IDLE;
          end
        end
        TPA_TIMED: begin
          if (mem_done_i) begin
            state_q <= TPA_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request to the flash array

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_q <= '0;
    end else if (rd_go) begin
      mem_req_q.rd    <= 1'b1;
      mem_req_q.cfg   <= ptr_acc[TPA_CFG_BIT];
      mem_req_q.addr  <= ptr_acc[TPA_ADDR_W-1:0];
    end else if (timed_go) begin
      mem_req_q.prog  <= reg_wdata_i[TPA_CTRL_WR];
      mem_req_q.erase <= reg_wdata_i[TPA_CTRL_ER] && !reg_wdata_i[TPA_CTRL_WR];
      mem_req_q.cfg   <= ptr_q[TPA_CFG_BIT];
      // block number only; low six bits forced to zero
      mem_req_q.addr  <= {ptr_q[TPA_ADDR_W-1:TPA_BLK_LSB],
                          {TPA_BLK_LSB{1'b0}}};
    end else if (mem_done_i) begin
      mem_req_q.rd    <= 1'b0;
      mem_req_q.prog  <= 1'b0;
      mem_req_q.erase <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table latch

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= TPA_LATCH_RST;
    end else if (state_q == TPA_READ && mem_done_i) begin
      latch_q <= mem_rdata_i;
    end else if (reg_wr_i && reg_addr_i == TPA_ADDR_LATCH) begin
      latch_q <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table pointer: automatic updates, then software byte writes

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= TPA_PTR_RST;
    end else if ((rd_go || op_i.wr) && state_q == TPA_IDLE) begin
      unique case (op_i.upd)
        TPA_UPD_NONE:     ptr_q <= ptr_q;
        TPA_UPD_POST_INC: ptr_q <= ptr_inc;
        TPA_UPD_POST_DEC: ptr_q <= ptr_dec;
        TPA_UPD_PRE_INC:  ptr_q <= ptr_inc;
      endcase
    end else if (reg_wr_i) begin
      // three byte registers form the pointer
      if (reg_addr_i == TPA_ADDR_PTR_LO) begin
        ptr_q[7:0] <= reg_wdata_i;
      end
      if (reg_addr_i == TPA_ADDR_PTR_HI) begin
        ptr_q[15:8] <= reg_wdata_i;
      end
      if (reg_addr_i == TPA_ADDR_PTR_UP) begin
        ptr_q[TPA_PTR_W-1:16] <= reg_wdata_i[TPA_UP_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // holding registers: one per low-pointer index, kept until a timed write

  for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        hold_q[i] <= TPA_HOLD_RST;
      end else if (state_q == TPA_TIMED && mem_done_i && mem_req_q.prog) begin
        hold_q[i] <= TPA_HOLD_RST;
      end else if (state_q == TPA_IDLE && op_i.wr && !op_i.rd
                   && ptr_acc[TPA_HOLD_LSB-1:0] == 5'(i)) begin
        hold_q[i] <= latch_q;
      end
    end
  end

  // flash array fetches holding bytes by index while programming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_data_o <= TPA_HOLD_RST;
    end else begin
      hold_data_o <= hold_q[hold_idx_i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data in the cycle after the strobe

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= TPA_ZERO8;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        TPA_ADDR_LATCH:  rdata_q <= latch_q;
        TPA_ADDR_PTR_LO: rdata_q <= ptr_q[7:0];
        TPA_ADDR_PTR_HI: rdata_q <= ptr_q[15:8];
        TPA_ADDR_PTR_UP: rdata_q <= {2'b00, ptr_q[TPA_PTR_W-1:16]};
        TPA_ADDR_CTRL:   rdata_q <= {6'h00, mem_req_q.erase, mem_req_q.prog};
        TPA_ADDR_STAT:   rdata_q <= {7'h00, state_q != TPA_IDLE};
        default:         rdata_q <= TPA_ZERO8;       // unmapped reads as zero
      endcase
    end else begin
      rdata_q <= TPA_ZERO8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      // follows the next state, so busy drops in the same edge as the flash request
      busy_o <= ((state_q != TPA_IDLE) && !mem_done_i) || rd_go
                || (timed_go && (reg_wdata_i[TPA_CTRL_WR] || reg_wdata_i[TPA_CTRL_ER]));
    end
  end

  assign reg_rdata_o = rdata_q;
  assign mem_req_o   = mem_req_q;

endmodule // tpa_table_access

/* File: tpa_table_access_asserts.sv */
// assertion checker for the table pointer access block
module tpa_table_access_asserts import tpa_pkg::*; #(
  parameter int HOLD_N = 32
) (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic [2:0]   reg_addr_i,
  input wire logic [7:0]   reg_wdata_i,
  input wire logic         reg_wr_i,
  input wire logic         reg_rd_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire tpa_op_t      op_i,
  input wire tpa_mem_req_t mem_req_o,
  input wire logic         mem_done_i,
  input wire logic         busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // table reads: request follows an accepted op and is held until the flash answers
  rd_start_a: assert property (op_i.rd && !busy_o |=> mem_req_o.rd && busy_o)
    else $error("table read did not start");
  rd_hold_a: assert property (mem_req_o.rd && !mem_done_i |=> mem_req_o.rd)
    else $error("read request dropped early");
  rd_end_a: assert property (mem_req_o.rd && mem_done_i |=> !mem_req_o.rd && !busy_o)
    else $error("read request outlived completion");
  busy_idle_a: assert property (!busy_o |-> !(mem_req_o.rd || mem_req_o.prog || mem_req_o.erase))
    else $error("flash request while idle");
  // timed writes start on a control write; timed operations address whole blocks only
  ctrl_start_a: assert property (reg_wr_i && reg_addr_i == TPA_ADDR_CTRL && reg_wdata_i[0]
    && !busy_o && !op_i.rd && !op_i.wr |=> mem_req_o.prog && busy_o)
    else $error("timed write did not start");
  blk_prog_a: assert property (mem_req_o.prog |-> mem_req_o.addr[5:0] == 6'h00)
    else $error("program address not block aligned");
  blk_erase_a: assert property (mem_req_o.erase |-> mem_req_o.addr[5:0] == 6'h00)
    else $error("erase address not block aligned");
  ////////////////////////////////////////
  // register port: data only in the cycle after a read strobe
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  unmap_rd_a: assert property (reg_rd_i && reg_addr_i > 3'h5 |=> reg_rdata_o == 8'h00)
    else $error("unmapped index returned data");
  // upper byte keeps only six bits; a quiet cycle between write and read is required
  ptr_up_a: assert property (reg_wr_i && reg_addr_i == TPA_ADDR_PTR_UP && !op_i.rd && !op_i.wr
    ##1 !reg_wr_i && !op_i.rd && !op_i.wr ##1 reg_rd_i && reg_addr_i == TPA_ADDR_PTR_UP
    |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h3F))
    else $error("upper pointer byte readback wrong");
  rd_done_c: cover property (mem_req_o.rd && mem_done_i);
  prog_done_c: cover property (mem_req_o.prog && mem_done_i);
  erase_done_c: cover property (mem_req_o.erase && mem_done_i);
endmodule // tpa_table_access_asserts

/* File: tpa_flash_model.sv */
// behavioural flash array answering table reads and timed operations
module tpa_flash_model import tpa_pkg::*; (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire tpa_mem_req_t req_i,
  input  wire logic         slow_i,
  output logic [7:0]        rdata_o,
  output logic              done_o
);
  logic [3:0] cnt_q;
  logic [7:0] byte_w;
  // pattern mixes both address ends and the space select
  assign byte_w = req_i.addr[7:0] ^ req_i.addr[20:13] ^ {req_i.cfg, 7'h00};
  // outside the done cycle the bus shows the inverse, so stale sampling never matches
  assign rdata_o = done_o ? byte_w : ~byte_w;
  // slow mode stretches the answer to exercise the held request
  always_ff @(posedge clk_i) begin
    if (rst_i || done_o || !(req_i.rd || req_i.prog || req_i.erase)) begin
      cnt_q  <= 4'h0;
      done_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 4'h1;
      done_o <= cnt_q == (slow_i ? 4'h9 : 4'h0);
    end
  end
endmodule // tpa_flash_model

/* File: tpa_table_access_tb.sv */
// self-checking testbench for the table pointer access block
module tpa_table_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tpa_pkg::*;
  logic         clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
  logic [2:0]   reg_addr_i = 3'h0;
  logic [7:0]   reg_wdata_i = 8'h00, reg_rdata_o, mem_rdata_i, hold_data_o;
  logic         mem_done_i, busy_o;
  logic [4:0]   hold_idx_i = 5'h00;
  tpa_op_t      op_i = '0;
  tpa_mem_req_t mem_req_o;
  int           errors = 0, checks = 0;
  logic [21:0]  p, q;
  logic [21:0]  pt [4] = '{22'h012345, 22'h3FFFFF, 22'h200000, 22'h1FFFFF};
  tpa_table_access #(.HOLD_N(32)) DUT (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .op_i, .mem_req_o, .mem_rdata_i, .mem_done_i, .hold_data_o,
    .hold_idx_i, .busy_o);
  tpa_flash_model FM (.clk_i, .rst_i, .req_i(mem_req_o), .slow_i(slow), .rdata_o(mem_rdata_i),
    .done_o(mem_done_i));
  initial forever #50 clk_i = ~clk_i;
  ////////////////////////////////////////
  function automatic logic [7:0] fb(input logic [21:0] a);
    return a[7:0] ^ a[20:13] ^ {a[21], 7'h00};
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus cycles: strobe for one cycle, read data taken in the following cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // top bits of the upper byte are written as ones to prove they read back as zero
  task automatic setp(input logic [21:0] v);
    wr(TPA_ADDR_PTR_LO, v[7:0]);
    wr(TPA_ADDR_PTR_HI, v[15:8]);
    wr(TPA_ADDR_PTR_UP, {2'b11, v[21:16]});
  endtask
  task automatic getp(output logic [24:0] g);
    logic [7:0] u, h, l;
    rd(TPA_ADDR_PTR_UP, u);
    rd(TPA_ADDR_PTR_HI, h);
    rd(TPA_ADDR_PTR_LO, l);
    g = {1'b0, u, h, l};
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n == 50) chk(25'h0, 25'h1);
  endtask
  task automatic top(input logic r, input logic [1:0] u);
    @(posedge clk_i);
    op_i <= '{r, !r, tpa_upd_t'(u)};
    @(posedge clk_i);
    op_i <= '0;
    #1 idle();
  endtask
  task automatic hchk(input logic [4:0] i, input logic [7:0] e);
    @(posedge clk_i);
    hold_idx_i <= i;
    @(posedge clk_i);
    #1 chk(25'(hold_data_o), 25'(e));
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0]  b;
    logic [24:0] g;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    getp(g);
    chk(g, 25'h0);
    rd(TPA_ADDR_LATCH, b);
    chk(25'(b), 25'h0);
    rd(3'h7, b);
    chk(25'(b), 25'h0);
    // every update form of a table read, the three moving ones at the wrap points of the low 21 bits, fast and slow flash
    for (int k = 0; k < 4; k++) begin
      p = pt[k];
      slow <= k[0];
      setp(p);
      top(1'b1, 2'(k));
      q = {p[21], p[20:0] + (k == 2 ? 21'h1FFFFF : 21'(k != 0))};
      rd(TPA_ADDR_LATCH, b);
      chk(25'(b), 25'(fb(k == 3 ? q : p)));
      getp(g);
      chk(g, 25'(q));
    end
    // fill one row of holding registers with post-increment writes, each after a latch write
    setp(22'h000060);
    for (int i = 0; i < 32; i++) begin
      wr(TPA_ADDR_LATCH, 8'(i * 7 + 3));
      top(1'b0, 2'h1);
    end
    for (int i = 0; i < 32; i++) hchk(5'(i), 8'(i * 7 + 3));
    getp(g);
    chk(g, 25'h80);
    // timed write, then the holding registers return to the erased value
    p = 22'h2ABCDE;
    setp(p);
    getp(g);
    chk(g, 25'(p));
    wr(TPA_ADDR_CTRL, 8'h01);
    chk(mem_req_o, {3'b010, p[21], p[20:6], 6'h00});
    idle();
    hchk(5'h00, 8'hFF);
    hchk(5'h1F, 8'hFF);
    setp(22'h00007F);
    wr(TPA_ADDR_CTRL, 8'h02);
    chk(mem_req_o, {4'b0010, 21'h000040});
    idle();
    give_verdict();
  end
  // watchdog well beyond the expected run of about 360 cycles
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
endmodule // tpa_table_access_tb
bind tpa_table_access tpa_table_access_asserts #(.HOLD_N(HOLD_N)) CHK (.clk_i, .rst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .op_i, .mem_req_o,
  .mem_done_i, .busy_o);
